//--- logic/dinu_pkg.sv
package dinu_pkg;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 4;
	localparam int DSW_TIME_MS = 20;
	localparam int DSW_CYCLES = DSW_TIME_MS * 1000000 / CLK_PERIOD_NS;

	// ****************************************
	// Sizes, limits and reset values
	// ****************************************
	localparam int MAX_DIGITS = 8;
	localparam int NARROW_DIGITS = 4;
	localparam logic [4:0] SIGNED_DIGIT_BASE = 5'h10;
	localparam int CMP_BANK_BITS = 16;
	localparam int NUM_PROGS = 4;
	localparam int DIV_STEPS = 32;
	localparam logic [31:0] BCD16_LIMIT = 32'h0000270F;
	localparam logic [31:0] BCD32_LIMIT = 32'h05F5E0FF;
	localparam logic [63:0] DATA_RST = 64'h0000000000000000;
	localparam logic [CMP_BANK_BITS-1:0] CMP_RST = 16'h0000;
	localparam logic [2:0] WORDS_ONE = 3'h1;
	localparam logic [2:0] WORDS_TWO = 3'h2;
	localparam logic [2:0] WORDS_FOUR = 3'h4;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [3:0] {
		OP_SIGNED_COMPARE = 4'h0,
		OP_WIDENING_MOVE = 4'h1,
		OP_NARROWING_MOVE = 4'h2,
		OP_TO_BCD = 4'h3,
		OP_TO_BIN = 4'h4,
		OP_ADD = 4'h5,
		OP_SUB = 4'h6,
		OP_MUL = 4'h7,
		OP_DIV = 4'h8,
		OP_DIGIT_SWITCH_READ = 4'h9
	} dinu_op_t;

	typedef enum logic [1:0] {PROG_X = 2'h0, PROG_Y = 2'h1, PROG_XY = 2'h2, PROG_SUB = 2'h3} dinu_prog_t;

	typedef struct packed {
		dinu_op_t op;
		logic wide;
		logic drive;
		dinu_prog_t prog;
		logic [3:0] cmp_pos;
		logic [4:0] digits;
		logic [31:0] a;
		logic [31:0] b;
	} dinu_cmd_t;

	typedef struct packed {
		logic zero;
		logic borrow;
		logic carry;
	} dinu_flags_t;

	// Most significant digit first, so nibble 0 carries weight one
	function automatic logic [31:0] dinu_bcd_to_bin(input logic [31:0] bcd);
		logic [31:0] acc;
		acc = 32'h00000000;
		for (int i = MAX_DIGITS - 1; i >= 0; i--) begin
			acc = acc * 32'h0000000A + {28'h0000000, bcd[i*4 +: 4]};
		end
		return acc;
	endfunction : dinu_bcd_to_bin

endpackage : dinu_pkg

//--- logic/dinu_div.sv
`timescale 1ns/1ps
module dinu_div
	import dinu_pkg::*;
(
	// Clock and reset
	input wire logic clock_in,
	input wire logic resetn_in,
	// Request
	input wire logic start_in,
	input wire logic [31:0] dividend_in,
	input wire logic [31:0] divisor_in,
	// Answer
	output logic done_out,
	output logic [31:0] quot_out,
	output logic [31:0] rem_out
);
	import dinu_pkg::*;

	logic busy_q, busy_d, done_q, done_d;
	logic [5:0] cnt_q, cnt_d;
	logic [31:0] quot_q, quot_d, rem_q, rem_d, dvs_q, dvs_d;
	logic [32:0] trial;

	// ****************************************
	// Restoring division, one bit per cycle
	// ****************************************
	always_comb begin
		busy_d = busy_q;
		done_d = 1'b0;
		cnt_d = cnt_q;
		quot_d = quot_q;
		rem_d = rem_q;
		dvs_d = dvs_q;
		trial = {rem_q, quot_q[31]} - {1'b0, dvs_q};
		if (start_in && !busy_q) begin
			busy_d = 1'b1;
			cnt_d = 6'h00;
			quot_d = dividend_in;
			rem_d = 32'h00000000;
			dvs_d = divisor_in;
		end else if (busy_q) begin
			quot_d = {quot_q[30:0], ~trial[32]};
			rem_d = trial[32] ? {rem_q[30:0], quot_q[31]} : trial[31:0];
			cnt_d = cnt_q + 6'h01;
			if (cnt_q == 6'(DIV_STEPS - 1)) begin
				busy_d = 1'b0;
				done_d = 1'b1;
			end
		end
	end

	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			busy_q <= 1'b0;
			done_q <= 1'b0;
			cnt_q <= 6'h00;
			quot_q <= 32'h00000000;
			rem_q <= 32'h00000000;
			dvs_q <= 32'h00000000;
		end else begin
			busy_q <= busy_d;
			done_q <= done_d;
			cnt_q <= cnt_d;
			quot_q <= quot_d;
			rem_q <= rem_d;
			dvs_q <= dvs_d;
		end
	end

	assign done_out = done_q;
	assign quot_out = quot_q;
	assign rem_out = rem_q;

endmodule : dinu_div

//--- logic/dinu_dsw.sv
`timescale 1ns/1ps
module dinu_dsw
	import dinu_pkg::*;
#(
	parameter int DIGIT_CYCLES = dinu_pkg::DSW_CYCLES
) (
	// Clock and reset
	input wire logic clock_in,
	input wire logic resetn_in,
	// Request
	input wire logic start_in,
	input wire logic [3:0] count_in,
	input wire logic signed_in,
	// Switch pins
	input wire logic [4:0] digit_switch_in,
	output logic [MAX_DIGITS-1:0] digit_switch_sel_out,
	// Answer
	output logic done_out,
	output logic [31:0] value_out
);
	import dinu_pkg::*;

	typedef enum logic [2:0] {ST_IDLE = 3'b001, ST_SCAN = 3'b010, ST_CONV = 3'b100} dinu_dsw_st_t;

	dinu_dsw_st_t st_q, st_d;
	logic [31:0] tmr_q, tmr_d, bcd_q, bcd_d, val_q, val_d, bin;
	logic [3:0] idx_q, idx_d, cnt_q, cnt_d;
	logic sgn_mode_q, sgn_mode_d, neg_q, neg_d, done_q, done_d;
	logic [MAX_DIGITS-1:0] sel_q, sel_d;
	logic [3:0] nibble;

	// ****************************************
	// Scan sequencer
	// ****************************************
	always_comb begin
		st_d = st_q;
		tmr_d = tmr_q;
		bcd_d = bcd_q;
		val_d = val_q;
		idx_d = idx_q;
		cnt_d = cnt_q;
		sgn_mode_d = sgn_mode_q;
		neg_d = neg_q;
		done_d = 1'b0;
		sel_d = sel_q;
		// Signed mode moves the weights up one pin to make room for the sign
		nibble = sgn_mode_q ? digit_switch_in[4:1] : digit_switch_in[3:0];
		bin = dinu_bcd_to_bin(bcd_q);
		case (st_q)
			ST_IDLE: begin
				if (start_in) begin
					st_d = ST_SCAN;
					tmr_d = 32'h00000000;
					bcd_d = 32'h00000000;
					idx_d = 4'h0;
					cnt_d = count_in;
					sgn_mode_d = signed_in;
					neg_d = 1'b0;
					sel_d = {{(MAX_DIGITS-1){1'b0}}, 1'b1};
				end
			end
			ST_SCAN: begin
				// Full settle time per digit before the sample
				if (tmr_q == 32'(DIGIT_CYCLES - 1)) begin
					tmr_d = 32'h00000000;
					bcd_d[idx_q*4 +: 4] = nibble;
					if (sgn_mode_q) begin
						neg_d = digit_switch_in[0];
					end
					if (idx_q == cnt_q - 4'h1) begin
						sel_d = '0;
						st_d = ST_CONV;
					end else begin
						idx_d = idx_q + 4'h1;
						sel_d = {sel_q[MAX_DIGITS-2:0], 1'b0};
					end
				end else begin
					tmr_d = tmr_q + 32'h00000001;
				end
			end
			ST_CONV: begin
				val_d = neg_q ? 32'h00000000 - bin : bin;
				done_d = 1'b1;
				st_d = ST_IDLE;
			end
			default: st_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			st_q <= ST_IDLE;
			tmr_q <= 32'h00000000;
			bcd_q <= 32'h00000000;
			val_q <= 32'h00000000;
			idx_q <= 4'h0;
			cnt_q <= 4'h0;
			sgn_mode_q <= 1'b0;
			neg_q <= 1'b0;
			done_q <= 1'b0;
			sel_q <= '0;
		end else begin
			st_q <= st_d;
			tmr_q <= tmr_d;
			bcd_q <= bcd_d;
			val_q <= val_d;
			idx_q <= idx_d;
			cnt_q <= cnt_d;
			sgn_mode_q <= sgn_mode_d;
			neg_q <= neg_d;
			done_q <= done_d;
			sel_q <= sel_d;
		end
	end

	assign digit_switch_sel_out = sel_q;
	assign done_out = done_q;
	assign value_out = val_q;

endmodule : dinu_dsw

//--- logic/dinu_unit.sv
// What this block does
// - Compare orders both operands as signed two's-complement numbers.
// - Compare writes less, equal, greater into three bits from the chosen position.
// - A compare not driven leaves its three result bits as they were.
// - Widening move copies 16 bits and fills bits 15 to 31 with bit 15.
// - Narrowing move puts bit 31 in bit 15, keeps low bits, drops 15..30.
// - Binary to BCD skips the write above 9,999 or 99,999,999.
// - BCD to binary skips the write when any nibble is not a decimal digit.
// - Add and subtract update the flag set of the issuing program type.
// - Signed multiply gives a negative product when exactly one operand is negative.
// - A 32-bit multiply returns the whole 64-bit product as four words.
// - Division by zero writes nothing.
// - Quotient negative when exactly one operand is negative; remainder follows dividend sign.
// - Unsigned switch reading takes four inputs as weights 1, 2, 4, 8.
// - Switch reader drives one to eight select outputs, one at a time.
// - Switch digits become binary: four in one word, eight in two.
// - Counts 1 to 4 need 16-bit operation, counts 5 to 8 need 32-bit.
// - Counts 17 to 24 read 1 to 8 digits signed, count minus 16.
// - Signed reading adds a sign input first, high meaning negative.
// - Signed reading of five to eight digits needs 32-bit operation.
// - Each select output holds for the digit-switching time before sampling.
`timescale 1ns/1ps
module dinu_unit
	import dinu_pkg::*;
#(
	parameter int DSW_DIGIT_CYCLES = dinu_pkg::DSW_CYCLES
) (
	// Clock and reset
	input wire logic clock_in,
	input wire logic resetn_in,
	// Command
	input wire logic cmd_valid_in,
	input wire dinu_pkg::dinu_cmd_t cmd_in,
	output logic cmd_ready_out,
	// Destination write
	output logic wr_out,
	output logic [63:0] wr_data_out,
	output logic [2:0] wr_words_out,
	output logic skip_out,
	// Result bits and flags
	output logic [dinu_pkg::CMP_BANK_BITS-1:0] cmp_bits_out,
	output dinu_pkg::dinu_flags_t [dinu_pkg::NUM_PROGS-1:0] flags_out,
	// Digit switch pins
	input wire logic [4:0] digit_switch_in,
	output logic [dinu_pkg::MAX_DIGITS-1:0] digit_switch_sel_out
);
	import dinu_pkg::*;

	// One-hot states; any stray code falls back to idle
	typedef enum logic [2:0] {ST_IDLE = 3'b001, ST_DIV = 3'b010, ST_DSW = 3'b100} dinu_st_t;

	dinu_st_t st_q, st_d;
	logic wr_q, wr_d, skip_q, skip_d;
	logic [63:0] data_q, data_d;
	logic [2:0] words_q, words_d;
	logic [CMP_BANK_BITS-1:0] cmp_q, cmp_d;
	dinu_flags_t [NUM_PROGS-1:0] flags_q, flags_d;
	logic wide_q, wide_d, qneg_q, qneg_d, rneg_q, rneg_d;

	logic signed [31:0] ea, eb;
	logic [31:0] mag_a, mag_b, limit, bcd_val, v, qv, rv;
	logic signed [33:0] sum;
	logic signed [63:0] prod;
	logic bcd_ok;
	logic div_start, div_done, dsw_start, dsw_done, dsw_signed, dsw_ok;
	logic [31:0] div_q, div_r, dsw_val;
	logic [3:0] dsw_cnt;

	// ****************************************
	// Operand preparation
	// ****************************************
	always_comb begin
		// Narrow operands sign-extended so one datapath serves both widths
		ea = cmd_in.wide ? $signed(cmd_in.a) : $signed({{16{cmd_in.a[15]}}, cmd_in.a[15:0]});
		eb = cmd_in.wide ? $signed(cmd_in.b) : $signed({{16{cmd_in.b[15]}}, cmd_in.b[15:0]});
		mag_a = ea[31] ? 32'h00000000 - ea : ea;
		mag_b = eb[31] ? 32'h00000000 - eb : eb;
		limit = cmd_in.wide ? BCD32_LIMIT : BCD16_LIMIT;
		// Decimal digits of a, least significant nibble first
		v = ea;
		bcd_val = 32'h00000000;
		for (int i = 0; i < MAX_DIGITS; i++) begin
			bcd_val[i*4 +: 4] = 4'(v % 32'h0000000A);
			v = v / 32'h0000000A;
		end
		bcd_ok = 1'b1;
		for (int i = 0; i < MAX_DIGITS; i++) begin
			if ((cmd_in.wide || i < NARROW_DIGITS) && cmd_in.a[i*4 +: 4] > 4'h9) begin
				bcd_ok = 1'b0;
			end
		end
		sum = (cmd_in.op == OP_SUB) ? 34'(ea) - 34'(eb) : 34'(ea) + 34'(eb);
		prod = 64'(ea) * 64'(eb);
		// Digit count: plain 1..8, or signed as count plus 16
		dsw_signed = cmd_in.digits > SIGNED_DIGIT_BASE;
		dsw_cnt = dsw_signed ? 4'(cmd_in.digits - SIGNED_DIGIT_BASE) : cmd_in.digits[3:0];
		dsw_ok = (dsw_signed ? cmd_in.digits <= 5'h18 : cmd_in.digits <= 5'h08)
			&& dsw_cnt != 4'h0
			&& ((dsw_cnt > 4'(NARROW_DIGITS)) == cmd_in.wide);
	end

	// ****************************************
	// Divider result with sign rules
	// ****************************************
	always_comb begin
		// Signs go back onto the divider's magnitudes here
		qv = qneg_q ? 32'h00000000 - div_q : div_q;
		rv = rneg_q ? 32'h00000000 - div_r : div_r;
	end

	// ****************************************
	// Command sequencer
	// ****************************************
	always_comb begin
		st_d = st_q;
		wr_d = 1'b0;
		skip_d = 1'b0;
		data_d = data_q;
		words_d = words_q;
		cmp_d = cmp_q;
		flags_d = flags_q;
		wide_d = wide_q;
		qneg_d = qneg_q;
		rneg_d = rneg_q;
		div_start = 1'b0;
		dsw_start = 1'b0;
		case (st_q)
			ST_IDLE: begin
				// An undriven command is consumed with no effect at all
				if (cmd_valid_in && cmd_in.drive) begin
					wide_d = cmd_in.wide;
					case (cmd_in.op)
						OP_SIGNED_COMPARE: begin
							if (32'(cmd_in.cmp_pos) <= CMP_BANK_BITS - 3) begin
								// Bits outside the chosen three keep their value
								for (int i = 0; i < CMP_BANK_BITS; i++) begin
									if (i == 32'(cmd_in.cmp_pos)) cmp_d[i] = ea < eb;
									if (i == 32'(cmd_in.cmp_pos) + 1) cmp_d[i] = ea == eb;
									if (i == 32'(cmd_in.cmp_pos) + 2) cmp_d[i] = ea > eb;
								end
							end else begin
								// Refused rather than wrapped past the top of the bank
								skip_d = 1'b1;
							end
						end
						OP_WIDENING_MOVE: begin
							data_d = {32'h00000000, {17{cmd_in.a[15]}}, cmd_in.a[14:0]};
							words_d = WORDS_TWO;
							wr_d = 1'b1;
						end
						OP_NARROWING_MOVE: begin
							data_d = {48'h000000000000, cmd_in.a[31], cmd_in.a[14:0]};
							words_d = WORDS_ONE;
							wr_d = 1'b1;
						end
						OP_TO_BCD: begin
							// Negative values are refused along with those too large
							if (!ea[31] && ea <= $signed(limit)) begin
								data_d = {32'h00000000, bcd_val};
								words_d = cmd_in.wide ? WORDS_TWO : WORDS_ONE;
								wr_d = 1'b1;
							end else begin
								skip_d = 1'b1;
							end
						end
						OP_TO_BIN: begin
							if (bcd_ok) begin
								data_d = {32'h00000000, dinu_bcd_to_bin(cmd_in.wide ? cmd_in.a
									: {16'h0000, cmd_in.a[15:0]})};
								words_d = cmd_in.wide ? WORDS_TWO : WORDS_ONE;
								wr_d = 1'b1;
							end else begin
								skip_d = 1'b1;
							end
						end
						OP_ADD, OP_SUB: begin
							data_d = {32'h00000000, sum[31:0]};
							words_d = cmd_in.wide ? WORDS_TWO : WORDS_ONE;
							wr_d = 1'b1;
							// Carry and borrow mean signed overflow up and down
							if (cmd_in.wide) begin
								flags_d[cmd_in.prog].zero = sum[31:0] == 32'h00000000;
								flags_d[cmd_in.prog].carry = sum > 34'sh7FFFFFFF;
								flags_d[cmd_in.prog].borrow = sum < -34'sh80000000;
							end else begin
								flags_d[cmd_in.prog].zero = sum[15:0] == 16'h0000;
								flags_d[cmd_in.prog].carry = sum > 34'sh7FFF;
								flags_d[cmd_in.prog].borrow = sum < -34'sh8000;
							end
						end
						OP_MUL: begin
							// Narrow product fills two words, never more
							data_d = cmd_in.wide ? prod : {32'h00000000, prod[31:0]};
							words_d = cmd_in.wide ? WORDS_FOUR : WORDS_TWO;
							wr_d = 1'b1;
						end
						OP_DIV: begin
							if (eb == 32'sh00000000) begin
								skip_d = 1'b1;
							end else begin
								// Truncating division: quotient sign from the operand signs
								qneg_d = ea[31] ^ eb[31];
								rneg_d = ea[31];
								div_start = 1'b1;
								st_d = ST_DIV;
							end
						end
						OP_DIGIT_SWITCH_READ: begin
							if (dsw_ok) begin
								dsw_start = 1'b1;
								st_d = ST_DSW;
							end else begin
								skip_d = 1'b1;
							end
						end
						default: skip_d = 1'b1;
					endcase
				end
			end
			ST_DIV: begin
				if (div_done) begin
					// Remainder sits above the quotient, low word first
					data_d = wide_q ? {rv, qv} : {32'h00000000, rv[15:0], qv[15:0]};
					words_d = wide_q ? WORDS_FOUR : WORDS_TWO;
					wr_d = 1'b1;
					st_d = ST_IDLE;
				end
			end
			ST_DSW: begin
				// Written only once every digit is in
				if (dsw_done) begin
					data_d = {32'h00000000, dsw_val};
					words_d = wide_q ? WORDS_TWO : WORDS_ONE;
					wr_d = 1'b1;
					st_d = ST_IDLE;
				end
			end
			default: st_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			st_q <= ST_IDLE;
			wr_q <= 1'b0;
			skip_q <= 1'b0;
			data_q <= DATA_RST;
			words_q <= WORDS_ONE;
			cmp_q <= CMP_RST;
			flags_q <= '0;
			wide_q <= 1'b0;
			qneg_q <= 1'b0;
			rneg_q <= 1'b0;
		end else begin
			st_q <= st_d;
			wr_q <= wr_d;
			skip_q <= skip_d;
			data_q <= data_d;
			words_q <= words_d;
			cmp_q <= cmp_d;
			flags_q <= flags_d;
			wide_q <= wide_d;
			qneg_q <= qneg_d;
			rneg_q <= rneg_d;
		end
	end

	// ****************************************
	// Sub-units
	// ****************************************
	// Both sub-units start from the idle decode, one command at a time
	dinu_div u_div (
		.clock_in(clock_in),
		.resetn_in(resetn_in),
		.start_in(div_start),
		.dividend_in(mag_a),
		.divisor_in(mag_b),
		.done_out(div_done),
		.quot_out(div_q),
		.rem_out(div_r)
	);

	dinu_dsw #(
		.DIGIT_CYCLES(DSW_DIGIT_CYCLES)
	) u_dsw (
		.clock_in(clock_in),
		.resetn_in(resetn_in),
		.start_in(dsw_start),
		.count_in(dsw_cnt),
		.signed_in(dsw_signed),
		.digit_switch_in(digit_switch_in),
		.digit_switch_sel_out(digit_switch_sel_out),
		.done_out(dsw_done),
		.value_out(dsw_val)
	);

	// Long operations block new commands until their write is out
	assign cmd_ready_out = st_q == ST_IDLE;
	assign wr_out = wr_q;
	assign wr_data_out = data_q;
	assign wr_words_out = words_q;
	assign skip_out = skip_q;
	assign cmp_bits_out = cmp_q;
	assign flags_out = flags_q;

endmodule : dinu_unit

//--- sim/dinu_unit_asserts.sv
`timescale 1ns/1ps
module dinu_unit_asserts
	import dinu_pkg::*;
(
	// Clock and reset
	input wire logic clock_in,
	input wire logic resetn_in,
	// Command
	input wire logic cmd_valid_in,
	input wire dinu_pkg::dinu_cmd_t cmd_in,
	input wire logic cmd_ready_out,
	// Results
	input wire logic wr_out,
	input wire logic [63:0] wr_data_out,
	input wire logic skip_out,
	input wire logic [dinu_pkg::CMP_BANK_BITS-1:0] cmp_bits_out,
	input wire logic [dinu_pkg::MAX_DIGITS-1:0] digit_switch_sel_out
);
	logic take;
	logic [2:0] cmp_exp;
	assign take = cmd_valid_in && cmd_ready_out && cmd_in.drive;
	// Order is greater, equal, less from the top bit down
	assign cmp_exp = {$signed(cmd_in.a) > $signed(cmd_in.b), cmd_in.a == cmd_in.b,
		$signed(cmd_in.a) < $signed(cmd_in.b)};
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!resetn_in);
	sel_onehot_a: assert property ($onehot0(digit_switch_sel_out))
		else $error("more than one digit select active");
	sel_idle_a: assert property (cmd_ready_out |-> digit_switch_sel_out == 8'h00)
		else $error("digit select active while idle");
	cmp_result_a: assert property (take && cmd_in.op == OP_SIGNED_COMPARE && cmd_in.wide
		&& cmd_in.cmp_pos < 4'hE |=> cmp_bits_out[$past(cmd_in.cmp_pos) +: 3] == $past(cmp_exp))
		else $error("compare result bits wrong");
	cmp_hold_a: assert property (cmd_valid_in && cmd_ready_out && !cmd_in.drive
		|=> $stable(cmp_bits_out)) else $error("undriven command changed compare bits");
	widen_sign_a: assert property (take && cmd_in.op == OP_WIDENING_MOVE |=> wr_out
		&& wr_data_out[31:0] == {{16{$past(cmd_in.a[15])}}, $past(cmd_in.a[15:0])})
		else $error("widening move result wrong");
	narrow_bits_a: assert property (take && cmd_in.op == OP_NARROWING_MOVE |=> wr_out
		&& wr_data_out[15:0] == {$past(cmd_in.a[31]), $past(cmd_in.a[14:0])})
		else $error("narrowing move result wrong");
	bcd_range_a: assert property (take && cmd_in.op == OP_TO_BCD && !cmd_in.wide
		&& cmd_in.a[15:0] > 16'h270F |=> skip_out && !wr_out)
		else $error("out of range conversion written");
	add_sum_a: assert property (take && cmd_in.op == OP_ADD && !cmd_in.wide |=> wr_out
		&& wr_data_out[15:0] == $past(cmd_in.a[15:0] + cmd_in.b[15:0]))
		else $error("sum wrong");
	mul_sign_a: assert property (take && cmd_in.op == OP_MUL && cmd_in.wide
		&& cmd_in.a != 32'h0 && cmd_in.b != 32'h0
		|=> wr_out && wr_data_out[63] == $past(cmd_in.a[31] ^ cmd_in.b[31]))
		else $error("product sign wrong");
	div_zero_a: assert property (take && cmd_in.op == OP_DIV
		&& (cmd_in.wide ? cmd_in.b == 32'h0 : cmd_in.b[15:0] == 16'h0) ##0 1 |=> skip_out && !wr_out)
		else $error("division by zero written");
endmodule : dinu_unit_asserts

bind dinu_unit dinu_unit_asserts u_asserts (.clock_in, .resetn_in, .cmd_valid_in, .cmd_in,
	.cmd_ready_out, .wr_out, .wr_data_out, .skip_out, .cmp_bits_out, .digit_switch_sel_out);

//--- sim/dinu_switch_model.sv
`timescale 1ns/1ps
module dinu_switch_model (
	// Clock and reset
	input wire logic clock_in,
	input wire logic resetn_in,
	// Switch settings
	input wire logic signed_in,
	input wire logic neg_in,
	input wire logic [31:0] bcd_in,
	// Pins
	input wire logic [7:0] sel_in,
	output logic [4:0] pins_out
);
	logic [4:0] last_q;
	// ****************
	// Switch returns
	// ****************
	// Unselected returns float, so show a changing pattern, never a held value
	always_comb begin
		pins_out = ~last_q;
		for (int i = 0; i < 8; i++) begin
			if (sel_in[i]) begin
				pins_out = signed_in ? {bcd_in[i*4 +: 4], neg_in} : {1'b0, bcd_in[i*4 +: 4]};
			end
		end
	end
	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			last_q <= 5'h00;
		end else begin
			last_q <= pins_out;
		end
	end
endmodule : dinu_switch_model

//--- sim/test_dinu_unit.sv
`timescale 1ns/1ps
module test_dinu_unit;
	import dinu_pkg::*;
	localparam int D = 4;
	logic clock_in = 1'b0;
	logic resetn_in = 1'b0;
	logic cmd_valid_in = 1'b0;
	dinu_cmd_t cmd_in = '0;
	logic cmd_ready_out, wr_out, skip_out;
	logic [63:0] wr_data_out;
	logic [2:0] wr_words_out;
	logic [CMP_BANK_BITS-1:0] cmp_bits_out;
	dinu_flags_t [NUM_PROGS-1:0] flags_out;
	logic [4:0] digit_switch_in;
	logic [MAX_DIGITS-1:0] digit_switch_sel_out, sel_seen;
	logic [31:0] sw_bcd = 32'h0;
	logic sw_signed = 1'b0;
	logic sw_neg = 1'b0;
	logic g_drive = 1'b1;
	dinu_prog_t g_prog = PROG_X;
	logic [3:0] g_pos = 4'h0;
	logic [4:0] g_dig = 5'h00;
	int fails = 0;
	int checked = 0;
	int cycles = 0;
	int waited;
	always #2 clock_in = ~clock_in;
	dinu_unit #(.DSW_DIGIT_CYCLES(D)) dut (.clock_in, .resetn_in, .cmd_valid_in, .cmd_in,
		.cmd_ready_out, .wr_out, .wr_data_out, .wr_words_out, .skip_out, .cmp_bits_out,
		.flags_out, .digit_switch_in, .digit_switch_sel_out);
	dinu_switch_model model (.clock_in, .resetn_in, .signed_in(sw_signed), .neg_in(sw_neg),
		.bcd_in(sw_bcd), .sel_in(digit_switch_sel_out), .pins_out(digit_switch_in));
	// ****************
	// Shared tasks
	// ****************
	task automatic print_verdict();
		$display("checks %0d, mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : print_verdict
	task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask : check
	// Returns on write or skip, or after lim cycles for ops with no answer
	task automatic run(input dinu_op_t op, input logic wide, input logic [31:0] a,
		input logic [31:0] b, input int lim);
		// An edge passes first, so valid never falls and rises in one step
		do @(posedge clock_in) #1; while (cmd_ready_out !== 1'b1);
		cmd_in = {op, wide, g_drive, g_prog, g_pos, g_dig, a, b};
		cmd_valid_in = 1'b1;
		@(posedge clock_in) #1;
		cmd_valid_in = 1'b0;
		waited = 0;
		sel_seen = 8'h00;
		while (wr_out !== 1'b1 && skip_out !== 1'b1 && waited < lim) begin
			sel_seen |= digit_switch_sel_out;
			@(posedge clock_in) #1;
			waited++;
		end
	endtask : run
	// ****************
	// Scenarios
	// ****************
	task automatic t_compare();
		run(OP_SIGNED_COMPARE, 1'b0, 32'h0000FFF6, 32'h00000002, 2);
		check("cmp neg", cmp_bits_out, 16'h0001);
		g_pos = 4'h3;
		run(OP_SIGNED_COMPARE, 1'b1, 32'h00000001, 32'h80000000, 2);
		check("cmp pos3", cmp_bits_out, 16'h0021);
		g_pos = 4'hD;
		run(OP_SIGNED_COMPARE, 1'b0, 32'h5, 32'h5, 2);
		check("cmp pos13", cmp_bits_out, 16'h4021);
		g_drive = 1'b0;
		g_pos = 4'h0;
		run(OP_SIGNED_COMPARE, 1'b0, 32'h9, 32'h1, 2);
		check("cmp held", cmp_bits_out, 16'h4021);
		g_drive = 1'b1;
		g_pos = 4'hE;
		run(OP_SIGNED_COMPARE, 1'b0, 32'h9, 32'h1, 2);
		check("cmp pos14", {skip_out, cmp_bits_out}, {1'b1, 16'h4021});
		g_pos = 4'h0;
	endtask : t_compare
	task automatic t_moves();
		run(OP_WIDENING_MOVE, 1'b1, 32'h00008001, 32'h0, 4);
		check("widen", wr_data_out[31:0], 32'hFFFF8001);
		run(OP_NARROWING_MOVE, 1'b1, 32'h80012BCD, 32'h0, 4);
		check("narrow neg", wr_data_out[15:0], 16'hABCD);
		run(OP_NARROWING_MOVE, 1'b1, 32'h7FFF1234, 32'h0, 4);
		check("narrow pos", wr_data_out[15:0], 16'h1234);
	endtask : t_moves
	task automatic t_bcd();
		run(OP_TO_BCD, 1'b0, 32'h0000270F, 32'h0, 4);
		check("bcd 9999", wr_data_out[15:0], 16'h9999);
		run(OP_TO_BCD, 1'b0, 32'h00002710, 32'h0, 4);
		check("bcd over", skip_out, 1'b1);
		run(OP_TO_BCD, 1'b1, 32'h05F5E0FF, 32'h0, 4);
		check("bcd32 max", wr_data_out[31:0], 32'h99999999);
		run(OP_TO_BCD, 1'b1, 32'h05F5E100, 32'h0, 4);
		check("bcd32 over", skip_out, 1'b1);
		run(OP_TO_BIN, 1'b0, 32'h00001234, 32'h0, 4);
		check("bin", wr_data_out[15:0], 16'h04D2);
		run(OP_TO_BIN, 1'b0, 32'h000012A4, 32'h0, 4);
		check("bin bad", skip_out, 1'b1);
	endtask : t_bcd
	task automatic t_flags();
		logic [11:0] ef;
		ef = 12'h000;
		for (int p = 0; p < NUM_PROGS; p++) begin
			g_prog = dinu_prog_t'(p);
			run(OP_ADD, 1'b0, 32'h7FFF, 32'h1, 4);
			ef[3*p +: 3] = 3'h1;
			check("add sum", wr_data_out[15:0], 16'h8000);
			check("add flags", flags_out, ef);
		end
		g_prog = PROG_Y;
		run(OP_SUB, 1'b0, 32'h8000, 32'h1, 4);
		ef[5:3] = 3'h2;
		check("sub flags", {wr_data_out[15:0], flags_out}, {16'h7FFF, ef});
		g_prog = PROG_SUB;
		run(OP_SUB, 1'b0, 32'h5, 32'h5, 4);
		ef[11:9] = 3'h4;
		check("zero flags", {wr_data_out[15:0], flags_out}, {16'h0000, ef});
		g_prog = PROG_X;
	endtask : t_flags
	task automatic t_muldiv();
		run(OP_MUL, 1'b0, 32'hFFFD, 32'h7, 4);
		check("mul16", wr_data_out[31:0], 32'hFFFFFFEB);
		run(OP_MUL, 1'b1, 32'hFFFFFFFD, 32'h7, 4);
		check("mul neg", {wr_words_out, wr_data_out}, {3'h4, 64'hFFFFFFFFFFFFFFEB});
		run(OP_MUL, 1'b1, 32'h00010000, 32'h00010000, 4);
		check("mul 64", wr_data_out, 64'h0000000100000000);
		run(OP_DIV, 1'b1, 32'hFFFFFFF9, 32'h2, 60);
		check("div neg", wr_data_out, 64'hFFFFFFFFFFFFFFFD);
		run(OP_DIV, 1'b1, 32'h7, 32'hFFFFFFFE, 60);
		check("div rem", wr_data_out, 64'h00000001FFFFFFFD);
		run(OP_DIV, 1'b0, 32'hFFF9, 32'h2, 60);
		check("div16", wr_data_out[31:0], 32'hFFFFFFFD);
		run(OP_DIV, 1'b1, 32'h7, 32'h0, 60);
		check("div zero", {skip_out, wr_data_out[31:0]}, {1'b1, 32'hFFFFFFFD});
	endtask : t_muldiv
	task automatic read_sw(input logic [4:0] dig, input logic wide, input logic [31:0] bcd,
		input logic neg, input logic [31:0] exp, input int n);
		sw_bcd = bcd;
		sw_neg = neg;
		sw_signed = dig > 5'h10;
		g_dig = dig;
		run(OP_DIGIT_SWITCH_READ, wide, 32'h0, 32'h0, 8 * D + 20);
		if (n == 0) begin
			check("count refused", skip_out, 1'b1);
		end else begin
			check("sw value", wide ? wr_data_out[31:0] : wr_data_out[15:0], wide ? exp : exp[15:0]);
			check("sw time", waited, n * D + 2);
			check("sw selects", sel_seen, (1 << n) - 1);
		end
	endtask : read_sw
	task automatic t_switch();
		read_sw(5'h03, 1'b0, 32'h00000591, 1'b0, 32'h0000024F, 3);
		read_sw(5'h08, 1'b1, 32'h99999999, 1'b0, 32'h05F5E0FF, 8);
		read_sw(5'h12, 1'b0, 32'h00000042, 1'b0, 32'h0000002A, 2);
		read_sw(5'h14, 1'b0, 32'h00001234, 1'b1, 32'h0000FB2E, 4);
		read_sw(5'h18, 1'b1, 32'h12345678, 1'b1, 32'hFF439EB2, 8);
		read_sw(5'h05, 1'b0, 32'h0, 1'b0, 32'h0, 0);
		read_sw(5'h15, 1'b0, 32'h0, 1'b0, 32'h0, 0);
		read_sw(5'h19, 1'b1, 32'h0, 1'b0, 32'h0, 0);
	endtask : t_switch
	// ****************
	// Main sequence
	// ****************
	always @(posedge clock_in) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			print_verdict();
		end
	end
	initial begin
		repeat (8) @(posedge clock_in);
		#1;
		resetn_in = 1'b1;
		check("reset state", {cmd_ready_out, digit_switch_sel_out, flags_out, wr_words_out},
			{1'b1, 8'h00, 12'h000, 3'h1});
		t_compare();
		t_moves();
		t_bcd();
		t_flags();
		t_muldiv();
		t_switch();
		print_verdict();
	end
endmodule : test_dinu_unit
